// file: bench/pcm_highway_frame_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_highway_frame_timing_tb;
  import phw_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus, observed outputs and bookkeeping.
  logic        clk, rst, bclk_o, bclk_oe, fs_o, fs_oe, tx_valid, rx_ready;
  logic        rx_valid, rx_ovr, tx_rdy, tx_und, fstart, far_bclk, far_fs;
  logic        ovr_seen, und_seen, clk_q, fs_q, toggled;
  phw_mode_t   mode;
  logic [1:0]  rate;
  logic [3:0]  tx_en, tx_lines, tx_oe, tx_ctl_n, far_rx;
  logic [31:0] tx_data, rx_data;
  int          err_total, total_checks, cycles, frames, half;
  // Each pin resolves to whichever side drives it.
  wire         pin_bclk = bclk_oe ? bclk_o : far_bclk;
  wire         pin_fs   = fs_oe ? fs_o : far_fs;

  phw_port dut (.SYS_CLK_I(clk), .RST_I(rst), .MODE_I(mode), .RATE_I(rate),
    .TX_ENABLE_I(tx_en), .PCM_BIT_CLOCK_I(pin_bclk), .PCM_BIT_CLOCK_O(bclk_o),
    .PCM_BIT_CLOCK_OE_O(bclk_oe), .PCM_FRAME_SYNC_I(pin_fs), .PCM_FRAME_SYNC_O(fs_o),
    .PCM_FRAME_SYNC_OE_O(fs_oe), .PCM_RECEIVE_LINES_I(far_rx),
    .PCM_TRANSMIT_LINES_O(tx_lines), .PCM_TRANSMIT_LINES_OE_O(tx_oe),
    .TRANSMIT_DRIVE_CONTROL_N_O(tx_ctl_n), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
    .RX_READY_I(rx_ready), .RX_OVERRUN_O(rx_ovr), .TX_DATA_I(tx_data),
    .TX_VALID_I(tx_valid), .TX_READY_O(tx_rdy), .TX_UNDERRUN_O(tx_und),
    .FRAME_START_O(fstart));
  phw_far_end far (.pcm_bit_clock(far_bclk), .pcm_frame_sync(far_fs),
    .pcm_receive_lines(far_rx));

  // 10 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Inputs always change 1 ns after a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input phw_mode_t m);
    mode = m;
    rst  = 1'b1;
    tick(2);
    rst  = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Edge monitor; registered outputs are read before this edge updates them.
  always @(posedge clk) begin
    cycles++;
    // A hang counts as a mismatch and closes the run.
    if (cycles > 80000) begin
      err_total++;
      wrap_up();
    end
    if (rst) begin
      toggled = 1'b0;
    end else begin
      if (rx_ovr) ovr_seen = 1'b1;
      if (tx_und) und_seen = 1'b1;
      if (fstart) frames++;
      if (mode == MODE_MASTER) begin
        if (fs_o && !fs_q) chk("sync_on_rise", 32'(bclk_o && !clk_q), 32'h1);
        if (bclk_o != clk_q) begin
          if (toggled) chk("clock_half", 32'(half), 32'h2);
          toggled = 1'b1;
          half    = 1;
        end else half++;
      end
    end
    clk_q = bclk_o;
    fs_q  = fs_o;
  end

  // Frame length and sync duty for every rate code; pins driven as master.
  task automatic t_master_rates;
    int r;
    int ch;
    int cl;
    for (r = 0; r < 4; r++) begin
      rate = r[1:0];
      do_reset(MODE_MASTER);
      tick(1);
      chk("master_pins", {30'h0, bclk_oe, fs_oe}, 32'h3);
      // The first frame after reset opens at bit one and is short, so skip it.
      while (fs_o !== 1'b1) tick(1);
      while (fs_o !== 1'b0) tick(1);
      while (fs_o !== 1'b1) tick(1);
      ch = 0;
      cl = 0;
      while (fs_o === 1'b1) begin tick(1); ch++; end
      while (fs_o === 1'b0) begin tick(1); cl++; end
      chk("frame_len", 32'(ch + cl), 32'(4 * (256 << r)));
      chk("sync_high", 32'(ch), 32'(2 * (256 << r)));
    end
  endtask

  // One word on lines 0 and 2, then an empty slot that must release them.
  task automatic t_master_tx;
    logic [31:0] got;
    int i;
    int n;
    rate = 2'h0;
    tx_en = 4'h5;
    do_reset(MODE_MASTER);
    tx_data  = 32'hA5C3_3C5A;
    tx_valid = 1'b1;
    do tick(1); while (tx_rdy === 1'b1);
    tx_valid = 1'b0;
    got = 32'h0000_0000;
    i = 0;
    while (i < 8) begin
      tick(1);
      if (clk_q && !bclk_o && tx_oe !== 4'h0) begin
        chk("drive_enable", 32'(tx_oe), 32'h5);
        chk("drive_control", 32'(tx_ctl_n), 32'hA);
        for (n = 0; n < 4; n++) got[8*n+7-i] = tx_lines[n];
        i++;
      end
    end
    chk("tx_bits", got & 32'h00FF_00FF, 32'h00C3_005A);
    und_seen = 1'b0;
    tick(40);
    chk("released", 32'(tx_oe), 32'h0);
    chk("ctrl_released", 32'(tx_ctl_n), 32'hF);
    chk("underrun", 32'(und_seen), 32'h1);
  endtask

  // Three 8 kHz frames into a two-word buffer, then drain it.
  task automatic t_slave8k;
    rx_ready = 1'b0;
    do_reset(MODE_SLAVE_8K);
    tick(1);
    chk("slave_pins", {30'h0, bclk_oe, fs_oe}, 32'h0);
    frames   = 0;
    ovr_seen = 1'b0;
    far.send_frame(1'b0, 32'h1234_5678);
    far.send_frame(1'b0, 32'h9ABC_DEF0);
    far.send_frame(1'b0, 32'h0F1E_2D3C);
    tick(8);
    chk("frames_8k", 32'(frames), 32'h3);
    chk("overrun", 32'(ovr_seen), 32'h1);
    chk("rx_first", rx_data, 32'h1234_5678);
    rx_ready = 1'b1;
    tick(1);
    chk("rx_second", rx_data, 32'h9ABC_DEF0);
    tick(1);
    rx_ready = 1'b0;
    chk("rx_empty", 32'(rx_valid), 32'h0);
  endtask

  // A single 4 kHz sync sample marks bit zero.
  task automatic t_slave4k;
    do_reset(MODE_SLAVE_4K);
    frames = 0;
    far.send_frame(1'b1, 32'hC3A5_0FF0);
    tick(8);
    chk("frames_4k", 32'(frames), 32'h1);
    chk("rx_4k", rx_data, 32'hC3A5_0FF0);
  endtask

  initial begin
    rst = 1'b1;
    mode = MODE_MASTER;
    rate = 2'h0;
    tx_en = 4'h0;
    rx_ready = 1'b0;
    tx_data = 32'h0000_0000;
    tx_valid = 1'b0;
    {err_total, total_checks, cycles, frames, half} = '0;
    {ovr_seen, und_seen, clk_q, fs_q, toggled} = '0;
    tick(1);
    chk("rst_ctrl", 32'(tx_ctl_n), 32'hF);
    chk("rst_ready", 32'(tx_rdy), 32'h1);
    tick(1);
    t_master_rates();
    t_master_tx();
    t_slave8k();
    t_slave4k();
    wrap_up();
  end
endmodule
`default_nettype wire

// file: bench/phw_far_end.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far-end PCM chip that supplies clock, sync and receive data to a slave port.
module phw_far_end (
  // Pins driven towards the port.
  output logic       pcm_bit_clock,
  output logic       pcm_frame_sync,
  output logic [3:0] pcm_receive_lines
);
  // The clock stands still between frames and only runs inside a burst.
  initial begin
    pcm_bit_clock     = 1'b0;
    pcm_frame_sync    = 1'b0;
    pcm_receive_lines = 4'h0;
  end

  // One idle bit, then eight bits carrying one byte per line, first bit MSB.
  task automatic send_frame(input logic four_k, input logic [31:0] word);
    int i;
    int n;
    for (i = -1; i < 8; i++) begin
      pcm_bit_clock = 1'b1;
      if (!four_k) pcm_frame_sync = (i == 0);
      // Data moves only on rising edges, so the falling edge sees it settled.
      for (n = 0; n < 4; n++) begin
        pcm_receive_lines[n] = (i < 0) ? ~pcm_receive_lines[n] : word[8*n+7-i];
      end
      // each level lasts many sampling cycles.
      #400;
      pcm_bit_clock = 1'b0;
      // sync spans exactly one rising edge.
      if (four_k) pcm_frame_sync = (i == -1);
      #400;
    end
    pcm_frame_sync    = 1'b0;
    // Released data must not keep showing the last bit.
    pcm_receive_lines = ~pcm_receive_lines;
  endtask
endmodule
`default_nettype wire

// file: hdl/phw_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types of the PCM highway port.
package phw_pkg;

  // System clock rate that samples the highway and divides the bit clock.
  localparam int unsigned CLK_HZ   = 10_000_000;
  // Frame rate of the highway.
  localparam int unsigned FRAME_HZ = 8_000;
  // Nominal master bit clock rates; each sets only the frame length.
  localparam int unsigned RATE0_HZ = 2_048_000;
  localparam int unsigned RATE1_HZ = 4_096_000;
  localparam int unsigned RATE2_HZ = 8_192_000;
  localparam int unsigned RATE3_HZ = 16_384_000;
  // The bit clock may not exceed a quarter of the sampling clock,
  // so each half period lasts at least two system cycles.
  localparam int unsigned MIN_HALF = 2;

  // Half period in system cycles, rounded down and clamped at the floor.
  function automatic logic [3:0] half_of(input int unsigned hz);
    int unsigned q;
    q = CLK_HZ / (2 * hz);
    if (q < MIN_HALF) q = MIN_HALF;
    if (q > 15) q = 15;
    return q[3:0];
  endfunction

  // Half period counts for each rate select code.
  localparam logic [3:0]  HALF0 = half_of(RATE0_HZ);
  localparam logic [3:0]  HALF1 = half_of(RATE1_HZ);
  localparam logic [3:0]  HALF2 = half_of(RATE2_HZ);
  localparam logic [3:0]  HALF3 = half_of(RATE3_HZ);
  // Last bit index of a frame for each rate select code.
  localparam logic [10:0] LAST0 = 11'(RATE0_HZ / FRAME_HZ - 1);
  localparam logic [10:0] LAST1 = 11'(RATE1_HZ / FRAME_HZ - 1);
  localparam logic [10:0] LAST2 = 11'(RATE2_HZ / FRAME_HZ - 1);
  localparam logic [10:0] LAST3 = 11'(RATE3_HZ / FRAME_HZ - 1);

  // Reset values.
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [2:0]  POS_RST   = 3'h0;
  localparam logic [10:0] FRAME_RST = 11'h000;
  // Bit position that closes a byte.
  localparam logic [2:0]  POS_LAST  = 3'h7;
  // Depth of the master receive capture delay, matching the pin synchroniser.
  localparam int unsigned CAP_DELAY = 3;

  // Operating modes of the port.
  typedef enum logic [1:0] {
    MODE_MASTER,
    MODE_SLAVE_8K,
    MODE_SLAVE_4K
  } phw_mode_t;

endpackage
`default_nettype wire

// file: hdl/phw_port.sv
// Functional notes
// - 8 kHz slave samples sync on falling edges.
// - 8 kHz slave: low-to-high sample starts frame.
// - 4 kHz slave samples sync on rising edges.
// - 4 kHz slave: high sample starts frame.
// - Master drives clock and sync; slave receives.
// - Master raises sync on bit clock rising edge.
// - Master frame length is selectable; the bit clock is the same for every rate code.
// - Bit clock at most quarter of sampling clock.
// - Receive lines captured on falling edges.
// - Transmit bits launched on rising edges.
// - Transmit release happens on rising edges.
// - Drive controls update on rising edges, aligned.
`timescale 1ns/1ps
`default_nettype none
module phw_port (
  // Clock and reset.
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_I,
  // Configuration.
  input  wire phw_pkg::phw_mode_t   MODE_I,
  input  wire logic [1:0]           RATE_I,
  input  wire logic [3:0]           TX_ENABLE_I,
  // Bit clock pin.
  input  wire logic                 PCM_BIT_CLOCK_I,
  output logic                      PCM_BIT_CLOCK_O,
  output logic                      PCM_BIT_CLOCK_OE_O,
  // Frame sync pin.
  input  wire logic                 PCM_FRAME_SYNC_I,
  output logic                      PCM_FRAME_SYNC_O,
  output logic                      PCM_FRAME_SYNC_OE_O,
  // Serial lines.
  input  wire logic [3:0]           PCM_RECEIVE_LINES_I,
  output logic [3:0]                PCM_TRANSMIT_LINES_O,
  output logic [3:0]                PCM_TRANSMIT_LINES_OE_O,
  output logic [3:0]                TRANSMIT_DRIVE_CONTROL_N_O,
  // Receive word stream.
  output logic [31:0]               RX_DATA_O,
  output logic                      RX_VALID_O,
  input  wire logic                 RX_READY_I,
  output logic                      RX_OVERRUN_O,
  // Transmit word stream.
  input  wire logic [31:0]          TX_DATA_I,
  input  wire logic                 TX_VALID_I,
  output logic                      TX_READY_O,
  output logic                      TX_UNDERRUN_O,
  // Frame marker.
  output logic                      FRAME_START_O
);
  import phw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Shifts every byte lane one place towards its top bit.
  function automatic logic [31:0] shift_bytes(input logic [31:0] w, input logic [3:0] b);
    logic [31:0] r;
    r = w;
    for (int n = 0; n < 4; n++) begin
      r[8*n +: 8] = {w[8*n +: 7], b[n]};
    end
    return r;
  endfunction

  // Top bit of every byte lane, which is the bit that goes on the wire next.
  function automatic logic [3:0] top_bits(input logic [31:0] w);
    logic [3:0] r;
    r = 4'h0;
    for (int n = 0; n < 4; n++) begin
      r[n] = w[8*n+7];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic        master;          // Port runs its own bit clock and sync.
  logic [2:0]  bclk_s;          // Bit clock synchroniser chain.
  logic [2:0]  fs_s;            // Frame sync synchroniser chain.
  logic [3:0]  rx_s1;           // Receive line synchroniser, stage one.
  logic [3:0]  rx_s2;           // Receive line synchroniser, stage two.
  logic [3:0]  rx_s3;           // Receive line synchroniser, stage three.
  logic        bclk_f;          // Filtered incoming bit clock.
  logic        fs_f;            // Filtered incoming frame sync.
  logic        sl_rise;         // Incoming bit clock rose.
  logic        sl_fall;         // Incoming bit clock fell.
  logic        fs_at_fall;      // Sync seen at the previous falling edge.
  logic [3:0]  div_cnt;         // Master half period counter.
  logic [3:0]  half;            // Half period for the selected rate.
  logic [10:0] frame_last;      // Last bit index for the selected rate.
  logic [10:0] frame_cnt;       // Master bit index within the frame.
  logic [10:0] next_frame;      // Bit index after the coming rising edge.
  logic        m_rise;          // Master bit clock rises this cycle.
  logic        m_fall;          // Master bit clock falls this cycle.
  logic        rise_ev;         // Rising edge event in either mode.
  logic        fall_ev;         // Falling edge event in either mode.
  logic        sync8_start;     // Frame start found at a falling edge.
  logic        sync4_start;     // Frame start found at a rising edge.
  logic [2:0]  bit_pos;         // Byte position of the bit on the wire.
  logic [2:0]  next_pos;        // Byte position after the coming rise.
  logic [2:0]  fall_pos;        // Byte position of the bit being captured.
  logic [2:0]  cap_ev_d;        // Delayed master capture events.
  logic [2:0]  cap_pos_d [3];   // Delayed master capture positions.
  logic        cap_ev;          // Capture the receive lines now.
  logic [2:0]  cap_pos;         // Byte position of that capture.
  logic [31:0] rx_sh;           // Receive shift register, a byte per line.
  logic [31:0] rx_mem [2];      // Two-entry receive buffer.
  logic        rx_wp;           // Buffer write pointer.
  logic        rx_rp;           // Buffer read pointer.
  logic [1:0]  rx_cnt;          // Words held in the buffer.
  logic        push;            // A whole word was assembled.
  logic        pop;             // The user takes a word.
  logic [31:0] tx_hold;         // Word waiting for the next byte slot.
  logic        tx_full;         // The holding word is valid.
  logic [31:0] tx_sh;           // Transmit shift register.
  logic        load;            // A byte slot starts at this rise.

  assign master = (MODE_I == MODE_MASTER);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Every pin passes three flip-flops; the first feeds only the second.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bclk_s <= 3'h0;
      fs_s   <= 3'h0;
      rx_s1  <= 4'h0;
      rx_s2  <= 4'h0;
      rx_s3  <= 4'h0;
    end else begin
      bclk_s <= {bclk_s[1:0], PCM_BIT_CLOCK_I};
      fs_s   <= {fs_s[1:0], PCM_FRAME_SYNC_I};
      rx_s1  <= PCM_RECEIVE_LINES_I;
      rx_s2  <= rx_s1;
      rx_s3  <= rx_s2;
    end
  end

  // A level counts once stages two and three agree. This is why the far
  // end must keep sync pulses and clock phases over a few sampling cycles.
  // input phase width
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bclk_f  <= 1'b0;
      fs_f    <= 1'b0;
      sl_rise <= 1'b0;
      sl_fall <= 1'b0;
    end else begin
      sl_rise <= 1'b0;
      sl_fall <= 1'b0;
      if (bclk_s[1] == bclk_s[2] && bclk_s[2] != bclk_f) begin
        bclk_f  <= bclk_s[2];
        sl_rise <= bclk_s[2];
        sl_fall <= !bclk_s[2];
      end
      if (fs_s[1] == fs_s[2]) begin
        fs_f <= fs_s[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master bit clock and frame sync.

  // Rate select picks the half period and the frame length.
  always_comb begin
    half       = HALF0;
    frame_last = LAST0;
    if (RATE_I == 2'h1) begin
      half       = HALF1;
      frame_last = LAST1;
    end else if (RATE_I == 2'h2) begin
      half       = HALF2;
      frame_last = LAST2;
    end else if (RATE_I == 2'h3) begin
      half       = HALF3;
      frame_last = LAST3;
    end
  end

  assign m_rise = master && (div_cnt == half - 4'h1) && !PCM_BIT_CLOCK_O;
  assign m_fall = master && (div_cnt == half - 4'h1) && PCM_BIT_CLOCK_O;
  assign next_frame = (frame_cnt == frame_last) ? FRAME_RST : frame_cnt + 11'h001;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_cnt         <= 4'h0;
      PCM_BIT_CLOCK_O <= 1'b0;
    end else if (!master) begin
      div_cnt         <= 4'h0;
      PCM_BIT_CLOCK_O <= 1'b0;
    end else if (div_cnt == half - 4'h1) begin
      div_cnt         <= 4'h0;
      PCM_BIT_CLOCK_O <= !PCM_BIT_CLOCK_O;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Sync is high over the first half of the frame and only ever changes
  // together with a rising edge of the bit clock.
  // sync on rise
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      frame_cnt        <= FRAME_RST;
      PCM_FRAME_SYNC_O <= 1'b0;
    end else if (!master) begin
      frame_cnt        <= frame_last;
      PCM_FRAME_SYNC_O <= 1'b0;
    end else if (m_rise) begin
      frame_cnt        <= next_frame;
      PCM_FRAME_SYNC_O <= (next_frame <= (frame_last >> 1));
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PCM_BIT_CLOCK_OE_O  <= 1'b0;
      PCM_FRAME_SYNC_OE_O <= 1'b0;
    end else begin
      PCM_BIT_CLOCK_OE_O  <= master;
      PCM_FRAME_SYNC_OE_O <= master;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit position and frame alignment.

  assign rise_ev = master ? m_rise : sl_rise;
  assign fall_ev = master ? m_fall : sl_fall;

  assign sync8_start = (MODE_I == MODE_SLAVE_8K) && sl_fall && fs_f && !fs_at_fall;
  assign sync4_start = (MODE_I == MODE_SLAVE_4K) && sl_rise && fs_f;
  assign fall_pos    = sync8_start ? POS_RST : bit_pos;

  // Position of the bit that the coming rising edge launches.
  always_comb begin
    if (master) begin
      next_pos = next_frame[2:0];
    end else if (sync4_start) begin
      next_pos = POS_RST;
    end else begin
      next_pos = bit_pos + 3'h1;
    end
  end

  // Slaves behind a master find its frame start the same way as asks.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bit_pos    <= POS_RST;
      fs_at_fall <= 1'b0;
    end else begin
      if (rise_ev) begin
        bit_pos <= next_pos;
      end else if (sync8_start) begin
        bit_pos <= POS_RST;
      end
      if (sl_fall) begin
        fs_at_fall <= fs_f;
      end
    end
  end

  // One-cycle marker at each frame start.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FRAME_START_O <= 1'b0;
    end else begin
      FRAME_START_O <= (m_rise && next_frame == FRAME_RST) || sync8_start || sync4_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path.

  // In master mode the lines reach us three cycles late through the
  // synchroniser, so the capture is delayed by as much to see the level
  // that stood at the falling edge. A slave edge is already equally late.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cap_ev_d <= 3'h0;
      for (int i = 0; i < CAP_DELAY; i++) begin
        cap_pos_d[i] <= POS_RST;
      end
    end else begin
      cap_ev_d     <= {cap_ev_d[1:0], m_fall};
      cap_pos_d[0] <= bit_pos;
      cap_pos_d[1] <= cap_pos_d[0];
      cap_pos_d[2] <= cap_pos_d[1];
    end
  end

  assign cap_ev  = master ? cap_ev_d[2] : sl_fall;
  assign cap_pos = master ? cap_pos_d[2] : fall_pos;
  assign push    = cap_ev && cap_pos == POS_LAST;
  assign pop     = RX_VALID_O && RX_READY_I;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_sh <= WORD_RST;
    end else if (cap_ev) begin
      rx_sh <= shift_bytes(rx_sh, rx_s3);
    end
  end

  // Two-entry buffer. A word that finds it full is dropped and flagged,
  // since the highway itself can never be held back.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_mem[0]    <= WORD_RST;
      rx_mem[1]    <= WORD_RST;
      rx_wp        <= 1'b0;
      rx_rp        <= 1'b0;
      rx_cnt       <= 2'h0;
      RX_OVERRUN_O <= 1'b0;
    end else begin
      RX_OVERRUN_O <= push && rx_cnt == 2'h2 && !pop;
      if (push && (rx_cnt != 2'h2 || pop)) begin
        rx_mem[rx_wp] <= shift_bytes(rx_sh, rx_s3);
        rx_wp         <= !rx_wp;
      end
      if (pop) begin
        rx_rp <= !rx_rp;
      end
      if (push && (rx_cnt != 2'h2 || pop) && !pop) begin
        rx_cnt <= rx_cnt + 2'h1;
      end else if (pop && !push) begin
        rx_cnt <= rx_cnt - 2'h1;
      end
    end
  end

  assign RX_VALID_O = (rx_cnt != 2'h0);
  assign RX_DATA_O  = rx_mem[rx_rp];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path.

  assign load       = rise_ev && next_pos == POS_RST;
  assign TX_READY_O = !tx_full;

  // Holding word; it is only taken while empty, so set and clear never meet.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_hold <= WORD_RST;
      tx_full <= 1'b0;
    end else if (TX_VALID_I && !tx_full) begin
      tx_hold <= TX_DATA_I;
      tx_full <= 1'b1;
    end else if (load) begin
      tx_full <= 1'b0;
    end
  end

  // A byte slot without a word releases every line for the whole slot.
  // launch on rise
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_sh                      <= WORD_RST;
      PCM_TRANSMIT_LINES_O       <= 4'h0;
      PCM_TRANSMIT_LINES_OE_O    <= 4'h0;
      TRANSMIT_DRIVE_CONTROL_N_O <= 4'hF;
      TX_UNDERRUN_O              <= 1'b0;
    end else begin
      TX_UNDERRUN_O <= load && !tx_full && TX_ENABLE_I != 4'h0;
      if (load) begin
        tx_sh                      <= shift_bytes(tx_hold, 4'h0);
        PCM_TRANSMIT_LINES_O       <= tx_full ? top_bits(tx_hold) : 4'h0;
        PCM_TRANSMIT_LINES_OE_O    <= tx_full ? TX_ENABLE_I : 4'h0;
        TRANSMIT_DRIVE_CONTROL_N_O <= tx_full ? ~TX_ENABLE_I : 4'hF;
      end else if (rise_ev) begin
        tx_sh                <= shift_bytes(tx_sh, 4'h0);
        PCM_TRANSMIT_LINES_O <= top_bits(tx_sh);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_sync_on_rise: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $rose(PCM_FRAME_SYNC_O) |-> $rose(PCM_BIT_CLOCK_O))
    else $error("Master sync rose without a bit clock rise.");

  // The enables are registered, so the edge right after reset still shows
  // the reset value; the check starts one edge later and covers both modes.
  a_pin_direction: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    !$past(RST_I) |->
      PCM_BIT_CLOCK_OE_O == $past(master) && PCM_FRAME_SYNC_OE_O == $past(master))
    else $error("Clock and sync drive do not follow the mode.");

  a_clock_half_period: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ($rose(PCM_BIT_CLOCK_O) && $past(master, 2)) |->
      !$past(PCM_BIT_CLOCK_O, 1) && !$past(PCM_BIT_CLOCK_O, 2))
    else $error("Bit clock low phase shorter than two cycles.");

  a_clock_quarter_rate: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (master && $changed(PCM_BIT_CLOCK_O)) |=> (!master || $stable(PCM_BIT_CLOCK_O)))
    else $error("Bit clock faster than a quarter of the clock.");

  a_launch_on_rise: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $changed(PCM_TRANSMIT_LINES_O) |-> $past(rise_ev))
    else $error("Transmit bit changed off a rising edge.");

  a_release_on_rise: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $changed(PCM_TRANSMIT_LINES_OE_O) |-> $past(rise_ev) && $past(next_pos) == POS_RST)
    else $error("Transmit drive changed off a byte-start rise.");

  a_control_aligned: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $changed(TRANSMIT_DRIVE_CONTROL_N_O) |->
      $past(rise_ev) && TRANSMIT_DRIVE_CONTROL_N_O == ~PCM_TRANSMIT_LINES_OE_O)
    else $error("Drive control not aligned with transmit drive.");

  a_capture_on_fall: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $changed(rx_sh) |-> $past(master) ? $past(m_fall, 4) : $past(sl_fall))
    else $error("Receive capture off a falling edge.");

  a_frame_8k_start: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ((MODE_I == MODE_SLAVE_8K) && sl_fall && fs_f && !fs_at_fall) |=>
      bit_pos == POS_RST && FRAME_START_O)
    else $error("8 kHz frame start not taken at the falling edge.");

  a_frame_4k_start: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ((MODE_I == MODE_SLAVE_4K) && sl_rise && fs_f) |=> bit_pos == POS_RST && FRAME_START_O)
    else $error("4 kHz frame start not taken at the rising edge.");

endmodule
`default_nettype wire
